// *** rtl/fxr_ext_read_reg.sv ***
/*
 * Extended read register with drive strength, learning pattern enable and the
 * sticky program, erase and protection error flags, plus the dummy clock decoder.
 * Assumes program/erase engines on clk_sys report each finished operation as a
 * one-cycle pulse with its kind and outcome, and that commands arrive on sclk.
 */
module fxr_ext_read_reg import fxr_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic porn,
  input wire logic sclk,
  input wire logic linkRstn,
  input wire logic quadMode,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdData,
  input wire logic wpPinN,
  input wire logic opDone,
  input wire fxr_op_type opKind,
  input wire logic opFail,
  input wire logic targetProtected,
  input wire logic targetSuspended,
  input wire logic infoRowLocked,
  input wire logic modeAlreadyChosen,
  input wire logic lockFieldZero,
  input wire logic pwdMismatch,
  input wire logic statusWriteDisableBit,
  input wire logic blockProtectLevelHit,
  input wire logic nvEraseFail,
  input wire logic nvProgFail,
  output logic [3:0] dummyCycles_ff,
  output logic readAccept_ff,
  output logic readReject_ff,
  output logic [7:0] extReadReg_ff,
  output logic [7:0] nvExtReadReg_ff,
  output logic [2:0] driveStrength_ff,
  output logic learningPatternEnable_ff
);
  logic cmdToggle;
  logic [7:0] cmdCodeHeld;
  logic [7:0] cmdDataHeld;
  logic togSync1_ff;
  logic togSync2_ff;
  logic togPrev_ff;
  logic wpSync1_ff;
  logic wpSync2_ff;
  logic reloadPending_ff;
  logic [2:0] warmUp_ff;
  logic cmdEvent;
  logic [2:0] errFlags_ff;
  logic [2:0] nxt_errSet;
  logic errClear;
  logic isSetVolatile;
  logic isSetNonVolatile;
  logic isSoftReset;
  logic [7:0] writeValue;

  fxr_link_decode uLink (
    .sclk(sclk),
    .rstn(linkRstn),
    .quadMode(quadMode),
    .cmdValid(cmdValid),
    .cmdCode(cmdCode),
    .cmdData(cmdData),
    .dummyCycles_ff(dummyCycles_ff),
    .readAccept_ff(readAccept_ff),
    .readReject_ff(readReject_ff),
    .cmdToggle_ff(cmdToggle),
    .cmdCodeHeld_ff(cmdCodeHeld),
    .cmdDataHeld_ff(cmdDataHeld)
  );

  // The first flop of each synchroniser feeds only the second.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      togSync1_ff <= 1'b0;
      togSync2_ff <= 1'b0;
      togPrev_ff <= 1'b0;
    end else begin
      togSync1_ff <= cmdToggle;
      togSync2_ff <= togSync1_ff;
      togPrev_ff <= togSync2_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wpSync1_ff <= 1'b1;
      wpSync2_ff <= 1'b1;
    end else begin
      wpSync1_ff <= wpPinN;
      wpSync2_ff <= wpSync1_ff;
    end
  end

  // Settles once the toggle synchroniser holds a real sample again.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      warmUp_ff <= 3'h0;
    end else begin
      warmUp_ff <= {warmUp_ff[1:0], 1'b1};
    end
  end

  // Held opcode and data have been stable for two system clocks by now.
  // A reset of this side alone leaves the link toggle where it was, so the first
  // edges after release must not take that level for a new command.
  assign cmdEvent = warmUp_ff[2] && (togSync2_ff ^ togPrev_ff);
  assign isSetVolatile = cmdEvent && cmdCodeHeld == OP_SET_EXT_V;
  assign isSetNonVolatile = cmdEvent && cmdCodeHeld == OP_SET_EXT_NV;
  assign isSoftReset = cmdEvent && cmdCodeHeld == OP_SOFT_RESET;
  assign errClear = (cmdEvent && cmdCodeHeld == OP_CLEAR_ERRORS) || isSoftReset;
  assign writeValue = cmdDataHeld & EXT_WRITABLE_MASK;

  // Index 0 protection, 1 program, 2 erase, matching register bits 1 to 3.
  always_comb begin
    nxt_errSet = 3'h0;
    if (opDone) begin
      unique case (opKind)
        OPK_PAGE_PROG, OPK_PROT_BIT_PROG: begin
          if (targetProtected || targetSuspended) begin
            nxt_errSet = 3'h3;
          end else if (opFail) begin
            nxt_errSet = 3'h2;
          end
        end
        OPK_INFO_ROW_PROG: begin
          if (infoRowLocked) begin
            nxt_errSet = 3'h3;
          end else if (opFail) begin
            nxt_errSet = 3'h2;
          end
        end
        // Mode lock already chosen or both bits zero.
        OPK_MODE_LOCK_PROG: begin
          if (modeAlreadyChosen || lockFieldZero) begin
            nxt_errSet = 3'h3;
          end else if (opFail) begin
            nxt_errSet = 3'h2;
          end
        end
        OPK_PWD_UNLOCK: begin
          if (pwdMismatch) begin
            nxt_errSet = 3'h3;
          end else if (opFail) begin
            nxt_errSet = 3'h2;
          end
        end
        // Write-disable bit protects only while the pin is low.
        OPK_STATUS_WRITE: begin
          if (statusWriteDisableBit && !wpSync2_ff) begin
            nxt_errSet = 3'h5;
          end else begin
            nxt_errSet = {nvEraseFail, nvProgFail, 1'b0};
          end
        end
        // Erase and program halves reported apart.
        OPK_NV_REG_WRITE: begin
          nxt_errSet = {nvEraseFail, nvProgFail, 1'b0};
        end
        OPK_FUNC_WRITE: begin
          nxt_errSet = {1'b0, opFail, 1'b0};
        end
        OPK_SECTOR_ERASE, OPK_INFO_ROW_ERASE, OPK_PROT_BIT_ERASE: begin
          if (targetProtected || infoRowLocked) begin
            nxt_errSet = 3'h5;
          end else if (opFail) begin
            nxt_errSet = 3'h4;
          end
        end
        // Only level-bit protection rejects a chip erase.
        OPK_CHIP_ERASE: begin
          if (blockProtectLevelHit) begin
            nxt_errSet = 3'h5;
          end else if (opFail) begin
            nxt_errSet = 3'h4;
          end
        end
        default: begin
          nxt_errSet = 3'h0;
        end
      endcase
    end
  end

  // Sticky flags, a set beats a clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      errFlags_ff <= 3'h0;
    end else begin
      errFlags_ff <= (errClear ? 3'h0 : errFlags_ff) | nxt_errSet;
    end
  end

  // Non-volatile copy survives everything but power loss.
  always_ff @(posedge clk_sys or negedge porn) begin
    if (!porn) begin
      nvExtReadReg_ff <= EXT_RESET;
    end else if (isSetNonVolatile) begin
      nvExtReadReg_ff <= writeValue;
    end
  end

  // Reload waits for the clock after reset release.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reloadPending_ff <= 1'b1;
    end else begin
      reloadPending_ff <= isSoftReset;
    end
  end

  // Writable bits only; flags and bit 0 come from elsewhere.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      extReadReg_ff <= EXT_RESET;
    end else begin
      if (reloadPending_ff) begin
        extReadReg_ff[DRIVE_MSB:BIT_LEARN_EN] <= nvExtReadReg_ff[DRIVE_MSB:BIT_LEARN_EN];
      end else if (isSetVolatile || isSetNonVolatile) begin
        extReadReg_ff[DRIVE_MSB:BIT_LEARN_EN] <= writeValue[DRIVE_MSB:BIT_LEARN_EN];
      end
      extReadReg_ff[BIT_ERASE_ERR:BIT_PROT_ERR] <= (errClear ? 3'h0 : errFlags_ff) | nxt_errSet;
      extReadReg_ff[BIT_RESERVED] <= 1'b0;
    end
  end

  // Reserved codes fall back to the 50 percent default.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      driveStrength_ff <= DRIVE_50;
      learningPatternEnable_ff <= 1'b0;
    end else begin
      unique case (extReadReg_ff[DRIVE_MSB:DRIVE_LSB])
        DRIVE_RSVD_LO, DRIVE_RSVD_HI: begin
          driveStrength_ff <= DRIVE_50;
        end
        default: begin
          driveStrength_ff <= extReadReg_ff[DRIVE_MSB:DRIVE_LSB];
        end
      endcase
      learningPatternEnable_ff <= extReadReg_ff[BIT_LEARN_EN];
    end
  end

  a_flags_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    errFlags_ff[2] && !errClear |=> errFlags_ff[2] && extReadReg_ff[BIT_ERASE_ERR])
    else $error("Erase flag dropped without a clear.");
  a_clear_errors: assert property (@(posedge clk_sys) disable iff (!rstn)
    errClear && nxt_errSet == 3'h0 |=> errFlags_ff == 3'h0 && extReadReg_ff[3:1] == 3'h0)
    else $error("Clear command left an error flag set.");
  a_prog_protect_pair: assert property (@(posedge clk_sys) disable iff (!rstn)
    opDone && opKind == OPK_PAGE_PROG && targetProtected |=> extReadReg_ff[2:1] == 2'h3)
    else $error("Protected program did not set program and protection flags.");
  a_pwd_mismatch: assert property (@(posedge clk_sys) disable iff (!rstn)
    opDone && opKind == OPK_PWD_UNLOCK && pwdMismatch |=> errFlags_ff[1:0] == 2'h3)
    else $error("Password mismatch did not set the flags.");
  a_status_protect: assert property (@(posedge clk_sys) disable iff (!rstn)
    opDone && opKind == OPK_STATUS_WRITE && statusWriteDisableBit && !wpSync2_ff
    |=> errFlags_ff[2] && errFlags_ff[0])
    else $error("Protected status write did not set erase and protection flags.");
  a_chip_erase_asp: assert property (@(posedge clk_sys) disable iff (!rstn)
    opDone && opKind == OPK_CHIP_ERASE && !blockProtectLevelHit && !errFlags_ff[0]
    |=> !errFlags_ff[0])
    else $error("Chip erase set protection flag without level-bit protection.");
  a_set_keeps_flags: assert property (@(posedge clk_sys) disable iff (!rstn)
    isSetVolatile && nxt_errSet == 3'h0 && !errClear
    |=> extReadReg_ff[3:1] == $past(errFlags_ff) && extReadReg_ff[7:4] == $past(writeValue[7:4]))
    else $error("Set-parameter command disturbed the error flags.");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    reloadPending_ff |=> extReadReg_ff[BIT_RESERVED] == 1'b0
    && extReadReg_ff[7:4] == $past(nvExtReadReg_ff[7:4]))
    else $error("Reload from the non-volatile copy failed.");
  a_nv_fail_split: assert property (@(posedge clk_sys) disable iff (!rstn)
    opDone && opKind == OPK_NV_REG_WRITE && nvEraseFail && !nvProgFail && !errFlags_ff[1]
    |=> errFlags_ff[2] && !errFlags_ff[1])
    else $error("Non-volatile write erase failure set the wrong flag.");
  a_prog_fail_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    opDone && opKind == OPK_PAGE_PROG && opFail |=> errFlags_ff[1])
    else $error("Failed page program did not set the program flag.");
  a_erase_fail_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    opDone && opKind == OPK_CHIP_ERASE && opFail |=> errFlags_ff[2])
    else $error("Failed chip erase did not set the erase flag.");
  a_info_row_lock: assert property (@(posedge clk_sys) disable iff (!rstn)
    opDone && opKind == OPK_INFO_ROW_PROG && infoRowLocked |=> errFlags_ff[1:0] == 2'h3)
    else $error("Locked info row program did not set both flags.");
  a_mode_lock_bad: assert property (@(posedge clk_sys) disable iff (!rstn)
    opDone && opKind == OPK_MODE_LOCK_PROG && (modeAlreadyChosen || lockFieldZero)
    |=> errFlags_ff[1:0] == 2'h3)
    else $error("Bad mode lock program did not set both flags.");
  a_func_fail_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    opDone && opKind == OPK_FUNC_WRITE && opFail |=> errFlags_ff[1])
    else $error("Failed function register write did not set the program flag.");
  a_erase_protect: assert property (@(posedge clk_sys) disable iff (!rstn)
    opDone && opKind == OPK_SECTOR_ERASE && targetProtected |=> errFlags_ff[2] && errFlags_ff[0])
    else $error("Protected erase did not set erase and protection flags.");
  a_nv_write_copy: assert property (@(posedge clk_sys) disable iff (!rstn)
    isSetNonVolatile |=> nvExtReadReg_ff == $past(writeValue))
    else $error("Non-volatile set command did not update the copy.");
  a_drive_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
    extReadReg_ff[7:5] == DRIVE_RSVD_LO || extReadReg_ff[7:5] == DRIVE_RSVD_HI
    |=> driveStrength_ff == DRIVE_50)
    else $error("Reserved drive code did not fall back to the default.");
  a_learn_follows: assert property (@(posedge clk_sys) disable iff (!rstn)
    extReadReg_ff[BIT_LEARN_EN] |=> learningPatternEnable_ff)
    else $error("Learning pattern enable did not follow the register.");
  a_soft_reset: assert property (@(posedge clk_sys) disable iff (!rstn)
    isSoftReset && nxt_errSet == 3'h0 |=> errFlags_ff == 3'h0 && reloadPending_ff)
    else $error("Software reset did not clear the flags and reload.");
  c_set_during_clear: cover property (@(posedge clk_sys) disable iff (!rstn)
    errClear && nxt_errSet != 3'h0);
  c_nv_write: cover property (@(posedge clk_sys) disable iff (!rstn)
    isSetNonVolatile ##[1:200] isSoftReset);
  c_chip_erase_prot: cover property (@(posedge clk_sys) disable iff (!rstn)
    opDone && opKind == OPK_CHIP_ERASE && blockProtectLevelHit);
endmodule

// *** rtl/fxr_pkg.sv ***
/*
 * Shared constants for the extended read register and error flag block.
 * Assumes a serial flash command front end that decodes opcodes on the link clock.
 */
package fxr_pkg;
  // Command opcodes.
  localparam logic [7:0] OP_FAST_READ_A = 8'h0B;
  localparam logic [7:0] OP_FAST_READ_B = 8'h0C;
  localparam logic [7:0] OP_FAST_DTR_A = 8'h0D;
  localparam logic [7:0] OP_FAST_DTR_B = 8'h0E;
  localparam logic [7:0] OP_DUAL_OUT_A = 8'h3B;
  localparam logic [7:0] OP_DUAL_OUT_B = 8'h3C;
  localparam logic [7:0] OP_QUAD_OUT_A = 8'h6B;
  localparam logic [7:0] OP_QUAD_OUT_B = 8'h6C;
  localparam logic [7:0] OP_DUAL_IO_A = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO_B = 8'hBC;
  localparam logic [7:0] OP_DUAL_IO_DDR_A = 8'hBD;
  localparam logic [7:0] OP_DUAL_IO_DDR_B = 8'hBE;
  localparam logic [7:0] OP_QUAD_IO_A = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO_B = 8'hEC;
  localparam logic [7:0] OP_QUAD_IO_DDR_A = 8'hED;
  localparam logic [7:0] OP_QUAD_IO_DDR_B = 8'hEE;
  localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4B;
  localparam logic [7:0] OP_INFO_ROW_READ = 8'h68;
  localparam logic [7:0] OP_SET_EXT_NV = 8'h85;
  localparam logic [7:0] OP_SET_EXT_V = 8'h83;
  localparam logic [7:0] OP_CLEAR_ERRORS = 8'h82;
  localparam logic [7:0] OP_SOFT_RESET = 8'h99;
  // Default dummy clock counts.
  localparam logic [3:0] DUMMY_EIGHT = 4'h8;
  localparam logic [3:0] DUMMY_SIX = 4'h6;
  localparam logic [3:0] DUMMY_FOUR = 4'h4;
  localparam logic [3:0] DUMMY_NONE = 4'h0;
  // Extended read register layout.
  localparam int BIT_RESERVED = 0;
  localparam int BIT_PROT_ERR = 1;
  localparam int BIT_PROG_ERR = 2;
  localparam int BIT_ERASE_ERR = 3;
  localparam int BIT_LEARN_EN = 4;
  localparam int DRIVE_LSB = 5;
  localparam int DRIVE_MSB = 7;
  localparam logic [7:0] EXT_RESET = 8'hE0;
  localparam logic [7:0] EXT_WRITABLE_MASK = 8'hF0;
  // Drive strength codes.
  localparam logic [2:0] DRIVE_12P5 = 3'h1;
  localparam logic [2:0] DRIVE_25 = 3'h2;
  localparam logic [2:0] DRIVE_37P5 = 3'h3;
  localparam logic [2:0] DRIVE_75 = 3'h5;
  localparam logic [2:0] DRIVE_100 = 3'h6;
  localparam logic [2:0] DRIVE_50 = 3'h7;
  localparam logic [2:0] DRIVE_RSVD_LO = 3'h0;
  localparam logic [2:0] DRIVE_RSVD_HI = 3'h4;
  // Completed operation kinds reported by the program/erase engines.
  typedef enum logic [3:0] {
    OPK_NONE = 4'h0,
    OPK_PAGE_PROG = 4'h1,
    OPK_PROT_BIT_PROG = 4'h2,
    OPK_INFO_ROW_PROG = 4'h3,
    OPK_MODE_LOCK_PROG = 4'h4,
    OPK_PWD_UNLOCK = 4'h5,
    OPK_STATUS_WRITE = 4'h6,
    OPK_NV_REG_WRITE = 4'h7,
    OPK_FUNC_WRITE = 4'h8,
    OPK_SECTOR_ERASE = 4'h9,
    OPK_CHIP_ERASE = 4'hA,
    OPK_INFO_ROW_ERASE = 4'hB,
    OPK_PROT_BIT_ERASE = 4'hC
  } fxr_op_type;
endpackage

// *** rtl/fxr_link_decode.sv ***
/*
 * Link-clock side: decodes each command opcode into its dummy clock count and
 * hands the opcode and data byte to the system clock by a toggle handshake.
 * Assumes the host leaves several system clocks between two commands.
 */
module fxr_link_decode import fxr_pkg::*; (
  input wire logic sclk,
  input wire logic rstn,
  input wire logic quadMode,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdData,
  output logic [3:0] dummyCycles_ff,
  output logic readAccept_ff,
  output logic readReject_ff,
  output logic cmdToggle_ff,
  output logic [7:0] cmdCodeHeld_ff,
  output logic [7:0] cmdDataHeld_ff
);
  logic [3:0] nxt_dummy;
  logic nxt_read;
  logic nxt_reject;

  always_comb begin
    nxt_dummy = DUMMY_NONE;
    nxt_read = 1'b1;
    nxt_reject = 1'b0;
    unique case (cmdCode)
      OP_FAST_READ_A, OP_FAST_READ_B, OP_FAST_DTR_A, OP_FAST_DTR_B,
      OP_UNIQUE_ID_READ, OP_INFO_ROW_READ: begin
        nxt_dummy = quadMode ? DUMMY_SIX : DUMMY_EIGHT;
      end
      OP_DUAL_OUT_A, OP_DUAL_OUT_B, OP_QUAD_OUT_A, OP_QUAD_OUT_B: begin
        nxt_dummy = DUMMY_EIGHT;
        nxt_reject = quadMode;
      end
      // Dual I/O, refused in four-lane mode.
      OP_DUAL_IO_A, OP_DUAL_IO_B, OP_DUAL_IO_DDR_A, OP_DUAL_IO_DDR_B: begin
        nxt_dummy = DUMMY_FOUR;
        nxt_reject = quadMode;
      end
      OP_QUAD_IO_A, OP_QUAD_IO_B, OP_QUAD_IO_DDR_A, OP_QUAD_IO_DDR_B: begin
        nxt_dummy = DUMMY_SIX;
      end
      default: begin
        nxt_read = 1'b0;
      end
    endcase
  end

  // The count is only meaningful while the host clocks a frame; it holds otherwise.
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      dummyCycles_ff <= DUMMY_NONE;
      readAccept_ff <= 1'b0;
      readReject_ff <= 1'b0;
    end else if (cmdValid) begin
      dummyCycles_ff <= nxt_reject ? DUMMY_NONE : nxt_dummy;
      readAccept_ff <= nxt_read && !nxt_reject;
      readReject_ff <= nxt_read && nxt_reject;
    end
  end

  // Opcode and data are held stable until the next command, so the toggle alone crosses.
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      cmdToggle_ff <= 1'b0;
      cmdCodeHeld_ff <= 8'h00;
      cmdDataHeld_ff <= 8'h00;
    end else if (cmdValid) begin
      cmdToggle_ff <= !cmdToggle_ff;
      cmdCodeHeld_ff <= cmdCode;
      cmdDataHeld_ff <= cmdData;
    end
  end

  a_dual_io_dummy: assert property (@(posedge sclk) disable iff (!rstn)
    cmdValid && !quadMode && cmdCode == OP_DUAL_IO_A |=> dummyCycles_ff == 4'h4)
    else $error("Dual I/O read did not get four dummy clocks.");
  a_quad_fast_dummy: assert property (@(posedge sclk) disable iff (!rstn)
    cmdValid && quadMode && cmdCode == OP_FAST_READ_A |=> dummyCycles_ff == 4'h6)
    else $error("Four-lane fast read did not get six dummy clocks.");
  a_dual_ddr_refused: assert property (@(posedge sclk) disable iff (!rstn)
    cmdValid && quadMode && cmdCode == OP_DUAL_IO_DDR_A |=> readReject_ff && !readAccept_ff)
    else $error("Dual I/O DDR read accepted in four-lane mode.");
  a_quad_io_dummy: assert property (@(posedge sclk) disable iff (!rstn)
    cmdValid && cmdCode == OP_QUAD_IO_DDR_B |=> dummyCycles_ff == 4'h6 && readAccept_ff)
    else $error("Quad I/O read did not get six dummy clocks.");
  c_dual_ddr_refused: cover property (@(posedge sclk) disable iff (!rstn)
    cmdValid && quadMode && cmdCode == OP_DUAL_IO_DDR_B);
endmodule

// *** sim/fxr_host_model.sv ***
/*
 * Behavioural serial host that sends one command frame per change of go.
 * Assumes the bench changes go only after the previous frame reported done.
 */
module fxr_host_model (
  input wire logic go,
  input wire logic [7:0] goCode,
  input wire logic [7:0] goData,
  input wire logic goQuad,
  output logic done,
  output logic sclk,
  output logic quadMode,
  output logic cmdValid,
  output logic [7:0] cmdCode,
  output logic [7:0] cmdData
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    done = 1'b0;
    sclk = 1'b0;
    quadMode = 1'b0;
    cmdValid = 1'b0;
    cmdCode = 8'h00;
    cmdData = 8'hFF;
  end

  // The link clock only runs inside a frame, one 80 ns high pulse per command.
  always @(go) begin
    quadMode = goQuad;
    cmdValid = 1'b1;
    cmdCode = goCode;
    cmdData = goData;
    #77;
    sclk = 1'b1;
    #80;
    sclk = 1'b0;
    cmdValid = 1'b0;
    cmdCode = ~goCode;
    cmdData = ~goData;
    #83;
    done = ~done;
  end
endmodule

// *** sim/tb_top.sv ***
/*
 * Self-checking bench for the extended read register and error flag block.
 * Assumes the host model in fxr_host_model.sv and the fxr_pkg constants.
 */
module tb_top;
  import fxr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] OPS [19] = '{OP_FAST_READ_A, OP_FAST_READ_B, OP_FAST_DTR_A,
    OP_FAST_DTR_B, OP_UNIQUE_ID_READ, OP_INFO_ROW_READ, OP_DUAL_OUT_A, OP_DUAL_OUT_B,
    OP_QUAD_OUT_A, OP_QUAD_OUT_B, OP_DUAL_IO_A, OP_DUAL_IO_B, OP_DUAL_IO_DDR_A,
    OP_DUAL_IO_DDR_B, OP_QUAD_IO_A, OP_QUAD_IO_B, OP_QUAD_IO_DDR_A, OP_QUAD_IO_DDR_B, 8'h00};
  // A value of F in the four-lane table marks a command that must be refused.
  localparam logic [3:0] DSPI [19] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8,
    4'h8, 4'h4, 4'h4, 4'h4, 4'h4, 4'h6, 4'h6, 4'h6, 4'h6, 4'h0};
  localparam logic [3:0] DQPI [19] = '{4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'hF, 4'hF, 4'hF,
    4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'h6, 4'h6, 4'h6, 4'h6, 4'h0};
  localparam fxr_op_type KIND [20] = '{OPK_PAGE_PROG, OPK_PAGE_PROG, OPK_PROT_BIT_PROG,
    OPK_INFO_ROW_PROG, OPK_MODE_LOCK_PROG, OPK_MODE_LOCK_PROG, OPK_PWD_UNLOCK,
    OPK_NV_REG_WRITE, OPK_NV_REG_WRITE, OPK_STATUS_WRITE, OPK_STATUS_WRITE, OPK_FUNC_WRITE,
    OPK_SECTOR_ERASE, OPK_SECTOR_ERASE, OPK_INFO_ROW_ERASE, OPK_PROT_BIT_ERASE,
    OPK_CHIP_ERASE, OPK_CHIP_ERASE, OPK_PAGE_PROG, OPK_CHIP_ERASE};
  // Qualifier bits: wp low, fail, protected, suspended, info locked, mode chosen,
  // lock zero, password mismatch, write disable, level hit, nv erase fail, nv prog fail.
  localparam logic [11:0] QUAL [20] = '{12'h400, 12'h200, 12'h100, 12'h080, 12'h040,
    12'h020, 12'h010, 12'h002, 12'h001, 12'h808, 12'h008, 12'h400, 12'h400, 12'h200,
    12'h080, 12'h400, 12'h004, 12'h200, 12'h000, 12'h400};
  localparam logic [7:0] EXPF [20] = '{8'h02, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03,
    8'h04, 8'h02, 8'h05, 8'h00, 8'h02, 8'h04, 8'h05, 8'h05, 8'h04, 8'h05, 8'h00, 8'h00,
    8'h04};

  logic clk_sys, rstn, porn, linkRstn, opDone;
  logic go = 1'b0;
  logic [7:0] goCode = 8'h00;
  logic [7:0] goData = 8'h00;
  logic goQuad = 1'b0;
  logic [11:0] qual = 12'h000;
  fxr_op_type opKind;
  logic done, sclk, quadMode, cmdValid, wpPinN;
  logic [7:0] cmdCode, cmdData, extReadReg_ff, nvExtReadReg_ff;
  logic opFail, targetProtected, targetSuspended, infoRowLocked, modeAlreadyChosen;
  logic lockFieldZero, pwdMismatch, statusWriteDisableBit, blockProtectLevelHit;
  logic nvEraseFail, nvProgFail, readAccept_ff, readReject_ff, learningPatternEnable_ff;
  logic [3:0] dummyCycles_ff;
  logic [2:0] driveStrength_ff;
  int mismatches = 0;
  int tests_run = 0;

  assign wpPinN = ~qual[11];
  assign {opFail, targetProtected, targetSuspended, infoRowLocked, modeAlreadyChosen,
    lockFieldZero, pwdMismatch, statusWriteDisableBit, blockProtectLevelHit, nvEraseFail,
    nvProgFail} = qual[10:0];

  fxr_host_model i_host (.go(go), .goCode(goCode), .goData(goData), .goQuad(goQuad),
    .done(done), .sclk(sclk), .quadMode(quadMode), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdData(cmdData));

  fxr_ext_read_reg i_dut (.clk_sys(clk_sys), .rstn(rstn), .porn(porn), .sclk(sclk),
    .linkRstn(linkRstn), .quadMode(quadMode), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdData(cmdData), .wpPinN(wpPinN), .opDone(opDone), .opKind(opKind), .opFail(opFail),
    .targetProtected(targetProtected), .targetSuspended(targetSuspended),
    .infoRowLocked(infoRowLocked), .modeAlreadyChosen(modeAlreadyChosen),
    .lockFieldZero(lockFieldZero), .pwdMismatch(pwdMismatch),
    .statusWriteDisableBit(statusWriteDisableBit), .blockProtectLevelHit(blockProtectLevelHit),
    .nvEraseFail(nvEraseFail), .nvProgFail(nvProgFail), .dummyCycles_ff(dummyCycles_ff),
    .readAccept_ff(readAccept_ff), .readReject_ff(readReject_ff),
    .extReadReg_ff(extReadReg_ff), .nvExtReadReg_ff(nvExtReadReg_ff),
    .driveStrength_ff(driveStrength_ff), .learningPatternEnable_ff(learningPatternEnable_ff));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // The register effect crosses into clk_sys a few cycles after the frame's sclk edge, before done.
  task automatic send(input logic [7:0] code, input logic [7:0] data, input logic quad);
    logic d0;
    int n;
    d0 = done;
    n = 0;
    goCode = code;
    goData = data;
    goQuad = quad;
    go = ~go;
    while (done === d0 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
      report_and_stop();
    end else begin
      repeat (6) @(negedge clk_sys);
    end
  endtask

  task automatic do_op(input fxr_op_type k, input logic [11:0] q);
    opKind = k;
    qual = q;
    repeat (4) @(negedge clk_sys);
    opDone = 1'b1;
    @(negedge clk_sys);
    opDone = 1'b0;
    qual = 12'h000;
    opKind = OPK_NONE;
    @(negedge clk_sys);
  endtask

  task automatic t_dummy();
    logic [3:0] e;
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 19; i++) begin
        e = m ? DQPI[i] : DSPI[i];
        send(OPS[i], 8'h00, m[0]);
        check({4'h0, dummyCycles_ff}, (e == 4'hF) ? 8'h00 : {4'h0, e});
        check({6'h0, readAccept_ff, readReject_ff},
          {6'h0, e != 4'h0 && e != 4'hF, e == 4'hF});
      end
    end
  endtask

  task automatic t_regs();
    logic [2:0] c;
    check(extReadReg_ff, EXT_RESET);
    check({5'h0, driveStrength_ff}, {5'h0, DRIVE_50});
    send(OP_SET_EXT_V, 8'hAF, 1'b0);
    check(extReadReg_ff, 8'hA0);
    check(nvExtReadReg_ff, EXT_RESET);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      send(OP_SET_EXT_V, {c, 5'h1F}, 1'b0);
      check(extReadReg_ff, {c, 5'h10});
      check({5'h0, driveStrength_ff}, {5'h0, (c == 3'h0 || c == 3'h4) ? DRIVE_50 : c});
      check({7'h0, learningPatternEnable_ff}, 8'h01);
    end
  endtask

  task automatic t_flags();
    for (int i = 0; i < 20; i++) begin
      do_op(KIND[i], QUAL[i]);
      check({5'h0, extReadReg_ff[3:1]}, EXPF[i]);
      check({4'h0, extReadReg_ff[3:0]}, {3'h0, EXPF[i][2:0], 1'b0});
      send(OP_CLEAR_ERRORS, 8'h00, 1'b0);
      check({4'h0, extReadReg_ff[3:0]}, 8'h00);
    end
  endtask

  task automatic t_sticky();
    do_op(OPK_PAGE_PROG, 12'h200);
    send(OP_SET_EXT_V, 8'hFF, 1'b0);
    check(extReadReg_ff, 8'hF6);
    do_op(OPK_SECTOR_ERASE, 12'h000);
    check(extReadReg_ff, 8'hF6);
    send(OP_SOFT_RESET, 8'h00, 1'b0);
    check(extReadReg_ff, 8'hE0);
  endtask

  task automatic t_nv();
    send(OP_SET_EXT_NV, 8'h3F, 1'b0);
    check(nvExtReadReg_ff, 8'h30);
    check(extReadReg_ff, 8'h30);
    rstn = 1'b0;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(extReadReg_ff, 8'h30);
    send(OP_SET_EXT_NV, 8'hE0, 1'b0);
    check(nvExtReadReg_ff, EXT_RESET);
  endtask

  initial begin
    rstn = 1'b0;
    porn = 1'b0;
    linkRstn = 1'b0;
    opDone = 1'b0;
    opKind = OPK_NONE;
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    porn = 1'b1;
    linkRstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_regs();
    t_dummy();
    t_flags();
    t_sticky();
    t_nv();
    report_and_stop();
  end
endmodule
